// file: i2m_pkg.sv
// constants, types and state layouts of the two-wire bus master block
// assumes a single 250 MHz clock and an apb master reaching the registers
package i2m_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_SLV = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TOUT_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;

  // status fields
  localparam int ST_BERR_BIT = 2;
  localparam int ST_ARB_BIT = 3;
  localparam int ST_RECEIVED_ACK_FLAG_BIT = 4;
  localparam int ST_WIF_BIT = 6;
  localparam int ST_RIF_BIT = 7;

  // half scl period is this base plus baud
  localparam logic [8:0] HALF_BASE = 9'h005;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [4:0] BIT_ONE = 5'h01;
  localparam logic [4:0] ACK_BIT = 5'h08;
  localparam logic [4:0] LAST_BIT = 5'h10;

  // inactivity timeout
  localparam int TOUT_US = 50;
  localparam int CLK_MHZ = 250;
  localparam int TOUT_CYC = TOUT_US * CLK_MHZ;
  localparam logic [15:0] TCNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    BS_UNKNOWN = 2'b00,
    BS_IDLE = 2'b01,
    BS_OWNER = 2'b10,
    BS_BUSY = 2'b11
  } i2m_bus_e;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0000,
    M_WAIT = 4'b0001,
    M_START = 4'b0010,
    M_BIT_LO = 4'b0011,
    M_BIT_HI = 4'b0100,
    M_HOLD = 4'b0101,
    M_PRE_LO = 4'b0110,
    M_PRE_HI = 4'b0111
  } i2m_mst_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2m_line_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } i2m_sync_s;

  typedef struct packed {
    logic en;
    logic tout_en;
    i2m_bus_e bus;
    i2m_mst_e mst;
    logic [7:0] baud;
    logic [8:0] cnt;
    logic [4:0] bit_n;
    logic [7:0] shreg;
    logic [7:0] rx;
    logic rw;
    logic rep;
    logic hi_seen;
    logic master_write_flag;
    logic master_read_flag;
    logic received_ack_flag;
    logic arbitration_lost_flag;
    logic bus_error_flag;
    i2m_line_s oe;
    i2m_line_s lvl;
    logic [15:0] tcnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } i2m_st_s;

endpackage

// file: i2m_sync.sv
// two-flop synchroniser with edge detection for one bus line
// assumes the input is asynchronous to clk_sys
`timescale 1ns/100ps
module i2m_sync (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic d, // raw pin level
  output logic q, // synchronised level
  output logic rise, // one-cycle rising edge
  output logic fall // one-cycle falling edge
);
  import i2m_pkg::*;

  i2m_sync_s st;
  i2m_sync_s nx;

  // s1 feeds only s2, edges come from s2 and s3
  always_comb begin
    nx.s1 = d;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
  end

  // lines idle high, so reset to released level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= 3'b111;
    end else begin
      st <= nx;
    end
  end

  assign q = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;
endmodule

// file: i2m_master.sv
// two-wire bus master: bus state tracking, scl generation, address packet
// assumes an apb master on clk_sys and open-drain pads resolved outside
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
module i2m_master #(
  parameter int TIMEOUT_CYC = i2m_pkg::TOUT_CYC // inactivity timeout in clk_sys cycles
) (
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire i2m_pkg::i2m_line_s line_i, // scl/sda pin levels
  output i2m_pkg::i2m_line_s line_o, // scl/sda drive levels
  output i2m_pkg::i2m_line_s line_oe // scl/sda drive enables
);
  import i2m_pkg::*;

  i2m_st_s st;
  i2m_st_s n;

  logic scl_s;
  logic sda_s;
  logic sda_rise;
  logic sda_fall;

  // both lines monitored all the time the block is clocked
  i2m_sync u_scl (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(line_i.scl),
    .q(scl_s),
    .rise(),
    .fall()
  );

  i2m_sync u_sda (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(line_i.sda),
    .q(sda_s),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  logic start_det;
  logic stop_det;
  logic apb_wr;
  logic apb_setup;
  logic cmd_addr;
  logic cmd_stop;
  logic wr_stat;
  logic tout_hit;
  logic [8:0] half;
  logic lost;
  logic berr;
  logic own_start;

  // start and stop seen on the synchronised lines
  assign start_det = sda_fall & scl_s;
  assign stop_det = sda_rise & scl_s;
  assign half = {1'b0, st.baud} + HALF_BASE;

  // apb decode: write lands in the access cycle with pready high
  assign apb_setup = psel & ~penable & ~st.pready;
  assign apb_wr = psel & penable & pwrite & st.pready;
  assign wr_stat = apb_wr & (paddr == ADDR_STAT);
  assign cmd_addr = apb_wr & (paddr == ADDR_SLV) & st.en;
  assign cmd_stop = apb_wr & (paddr == ADDR_CTRL) & pwdata[CTRL_STOP_BIT] & st.en;
  // a count left over from an unsettled state must not fire once the state is known
  assign tout_hit = st.tout_en & (st.bus == BS_UNKNOWN | st.bus == BS_BUSY)
                    & (st.tcnt == 16'(TIMEOUT_CYC - 1));

  always_comb begin
    n = st;
    lost = 1'b0;
    berr = 1'b0;
    own_start = 1'b0;

    // apb slave: answer prepared in setup, completes one cycle later
    n.pready = 1'b0;
    if (apb_setup) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      case (paddr)
        ADDR_CTRL: n.prdata = {30'h0, st.tout_en, st.en};
        ADDR_STAT: n.prdata = {24'h0, st.master_read_flag, st.master_write_flag, st.oe.scl & (st.mst == M_HOLD),
                               st.received_ack_flag, st.arbitration_lost_flag, st.bus_error_flag, st.bus};
        ADDR_BAUD: n.prdata = {24'h0, st.baud};
        ADDR_SLV: n.prdata = {24'h0, st.shreg};
        ADDR_DATA: n.prdata = {24'h0, st.rx};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == ADDR_CTRL) begin
      n.en = pwdata[CTRL_EN_BIT];
      n.tout_en = pwdata[CTRL_TOUT_BIT];
    end
    if (apb_wr && paddr == ADDR_BAUD) begin
      n.baud = pwdata[7:0];
    end
    // write-one-to-clear; hardware sets below take priority
    if (wr_stat) begin
      n.master_write_flag = st.master_write_flag & ~pwdata[ST_WIF_BIT];
      n.master_read_flag = st.master_read_flag & ~pwdata[ST_RIF_BIT];
      n.arbitration_lost_flag = st.arbitration_lost_flag & ~pwdata[ST_ARB_BIT];
      n.bus_error_flag = st.bus_error_flag & ~pwdata[ST_BERR_BIT];
    end

    // inactivity counter runs only while the state is not settled
    if (scl_s && sda_s && st.tout_en && (st.bus == BS_UNKNOWN || st.bus == BS_BUSY) && !tout_hit) begin
      n.tcnt = st.tcnt + TCNT_ONE;
    end else begin
      n.tcnt = '0;
    end

    // master sequencer
    case (st.mst)
      M_IDLE, M_WAIT: begin
        n.oe = '0;
        if (cmd_addr) begin
          n.shreg = pwdata[7:0];
          n.rw = pwdata[0];
          n.master_write_flag = 1'b0;
          n.master_read_flag = 1'b0;
          n.mst = M_WAIT;
        end
        // busy or unknown bus defers the start
        if ((cmd_addr || st.mst == M_WAIT) && st.bus == BS_IDLE) begin
          n.mst = M_START;
          n.oe.sda = 1'b1;
          n.cnt = '0;
          own_start = 1'b1;
        end
      end
      M_START: begin
        n.cnt = st.cnt + CNT_ONE;
        if (st.cnt == half) begin
          n.oe.scl = 1'b1;
          n.cnt = '0;
          n.bit_n = '0;
          n.mst = M_BIT_LO;
        end
      end
      M_BIT_LO: begin
        n.cnt = st.cnt + CNT_ONE;
        // data changes only once scl is already low
        if (st.cnt == '0) begin
          n.oe.sda = (st.bit_n < ACK_BIT) ? ~st.shreg[7] : 1'b0;
        end
        if (st.cnt == half) begin
          n.oe.scl = 1'b0;
          n.cnt = '0;
          n.hi_seen = 1'b0;
          n.mst = M_BIT_HI;
        end
      end
      M_BIT_HI: begin
        // high time counts from the seen rise, so rise time adds on
        if (scl_s) begin
          n.cnt = st.cnt + CNT_ONE;
          if (!st.hi_seen) begin
            n.hi_seen = 1'b1;
            if (st.bit_n < ACK_BIT) begin
              lost = ~st.oe.sda & ~sda_s;
            end else if (st.bit_n == ACK_BIT) begin
              n.received_ack_flag = sda_s;
            end else begin
              n.rx = {st.rx[6:0], sda_s};
            end
          end
        end
        if (st.hi_seen && st.cnt == half) begin
          n.oe.scl = 1'b1;
          n.cnt = '0;
          n.bit_n = st.bit_n + BIT_ONE;
          n.mst = M_BIT_LO;
          if (st.bit_n < ACK_BIT) begin
            n.shreg = {st.shreg[6:0], 1'b0};
          end else if (st.bit_n == ACK_BIT && (st.received_ack_flag || !st.rw)) begin
            n.master_write_flag = 1'b1;
            n.mst = M_HOLD;
          end else if (st.bit_n == LAST_BIT) begin
            n.master_read_flag = 1'b1;
            n.received_ack_flag = 1'b0;
            n.mst = M_HOLD;
          end
        end
      end
      M_HOLD: begin
        n.oe.sda = 1'b0;
        if (cmd_addr) begin
          n.shreg = pwdata[7:0];
          n.rw = pwdata[0];
          n.master_write_flag = 1'b0;
          n.master_read_flag = 1'b0;
          n.rep = 1'b0;
          n.cnt = '0;
          n.mst = M_PRE_LO;
        end else if (cmd_stop) begin
          n.master_write_flag = 1'b0;
          n.master_read_flag = 1'b0;
          n.rep = 1'b1;
          n.cnt = '0;
          n.mst = M_PRE_LO;
        end
        // scl held low while a flag stands, and on leaving for M_PRE_LO
        n.oe.scl = n.master_write_flag | n.master_read_flag | (n.mst == M_PRE_LO);
      end
      M_PRE_LO: begin
        n.oe.scl = 1'b1;
        n.cnt = st.cnt + CNT_ONE;
        if (st.cnt == '0) begin
          n.oe.sda = st.rep;
        end
        if (st.cnt == half) begin
          n.oe.scl = 1'b0;
          n.cnt = '0;
          n.hi_seen = 1'b0;
          n.mst = M_PRE_HI;
        end
      end
      M_PRE_HI: begin
        if (scl_s) begin
          n.cnt = st.cnt + CNT_ONE;
          if (!st.hi_seen) begin
            n.hi_seen = 1'b1;
            lost = ~st.rep & ~sda_s;
          end
        end
        if (st.hi_seen && st.cnt == half) begin
          n.cnt = '0;
          if (st.rep) begin
            n.oe.sda = 1'b0; // sda rise with scl high is the stop
            n.mst = M_IDLE;
          end else begin
            n.oe.sda = 1'b1;
            n.mst = M_START;
          end
        end
      end
      default: begin
        n.mst = M_IDLE;
        n.oe = '0;
      end
    endcase

    // start/stop in mid packet is a bus error
    if ((st.mst == M_BIT_LO || st.mst == M_BIT_HI) && (start_det || stop_det)) begin
      berr = 1'b1;
    end
    // loss or error: flags, release both lines, back off
    if (lost || berr) begin
      n.master_write_flag = 1'b1;
      n.arbitration_lost_flag = 1'b1;
      n.bus_error_flag = st.bus_error_flag | berr | (n.bus_error_flag & ~lost);
      n.oe = '0;
      n.mst = M_IDLE;
    end

    // bus state tracking
    case (st.bus)
      BS_UNKNOWN: if (stop_det || tout_hit) n.bus = BS_IDLE;
      BS_IDLE: begin
        if (own_start) begin
          n.bus = BS_OWNER;
        end else if (start_det) begin
          n.bus = BS_BUSY;
        end
      end
      BS_BUSY: if (stop_det || tout_hit) n.bus = BS_IDLE;
      BS_OWNER: begin
        if (stop_det) begin
          n.bus = BS_IDLE;
        end else if (lost || berr) begin
          n.bus = BS_BUSY;
        end
      end
      default: n.bus = BS_UNKNOWN;
    endcase
    if (wr_stat && pwdata[1:0] == BS_IDLE) begin
      n.bus = BS_IDLE;
    end

    // disabled master: state unknown, sequencer and flags cleared
    if (!st.en) begin
      n.bus = BS_UNKNOWN;
      n.mst = M_IDLE;
      n.oe = '0;
      n.master_write_flag = 1'b0;
      n.master_read_flag = 1'b0;
      n.arbitration_lost_flag = 1'b0;
      n.bus_error_flag = 1'b0;
      n.received_ack_flag = 1'b0;
    end
    n.lvl = '0; // open drain only ever pulls low
  end

  // reset leaves bus state unknown (code 00)
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  // outputs come straight from the state register, no logic after the flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign line_o = st.lvl;
  assign line_oe = st.oe;

  // checks on the state record, all in the clk_sys domain
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // in hold the clock line must track the flags in every cycle, entry included
  hold_scl_a: assert property (st.mst == M_HOLD |-> st.oe.scl == (st.master_write_flag | st.master_read_flag))
    else $error("scl hold does not follow flags");
  disable_unknown_a: assert property (!st.en |=> st.bus == BS_UNKNOWN)
    else $error("bus state not unknown while disabled");
  enable_unknown_a: assert property ($rose(st.en) |-> st.bus == BS_UNKNOWN)
    else $error("bus state not unknown at enable");
  force_idle_a: assert property (st.en && wr_stat && pwdata[1:0] == BS_IDLE |=> st.bus == BS_IDLE)
    else $error("idle write did not force idle");
  stop_idle_a: assert property (st.en && !apb_wr && stop_det && st.bus != BS_IDLE |=> st.bus == BS_IDLE)
    else $error("stop did not return bus to idle");
  tout_idle_a: assert property (st.en && !apb_wr && tout_hit |=> st.bus == BS_IDLE)
    else $error("timeout did not give idle");
  arb_loss_a: assert property (st.en && !apb_wr && lost && !stop_det |=>
    st.master_write_flag && st.arbitration_lost_flag && st.oe == '0 && st.mst == M_IDLE) else $error("arbitration loss mishandled");
  owner_busy_a: assert property (st.en && !apb_wr && st.bus == BS_OWNER && lost && !stop_det
    |=> st.bus == BS_BUSY) else $error("owner not busy after loss");
  bus_err_a: assert property (st.en && berr |=> st.bus_error_flag && st.arbitration_lost_flag && st.master_write_flag)
    else $error("bus error flags missing");
  wait_idle_a: assert property (st.mst == M_WAIT && st.bus != BS_IDLE |=> st.mst != M_START)
    else $error("start issued on non-idle bus");
  low_time_a: assert property (st.mst == M_BIT_LO && st.cnt == half |=> st.mst == M_BIT_HI && !st.oe.scl)
    else $error("scl low phase length wrong");
endmodule

// file: i2m_peer_model.sv
// slave on the two-wire bus that can also act as a rival master pulling sda
// assumes the bench resolves the wire levels with pull-ups
`timescale 1ns/100ps
module i2m_peer_model (
  input wire logic scl, // scl wire level
  input wire logic sda, // sda wire level
  input wire logic [6:0] my_addr, // address answered
  input wire logic [7:0] tx_byte, // byte sent on reads
  input wire logic [3:0] clash_bit, // rival pulls sda in this bit, 0 never
  output logic sda_pull, // 1 pulls sda low
  output logic [7:0] got // last address byte seen
);
  int n;
  logic rd;
  initial begin
    n = 0;
    rd = 1'h0;
    sda_pull = 1'h0;
    got = 8'h00;
  end
  // start restarts the bit count, stop frees the line
  always @(negedge sda) if (scl) begin
    n = 0;
    rd = 1'h0;
  end
  always @(posedge sda) if (scl) sda_pull = 1'h0;
  // bits taken on scl rise, msb first
  always @(posedge scl) begin
    if (n < 8) got = {got[6:0], sda};
    n = n + 1;
  end
  // sda moves only while scl is low, so no false start or stop
  always @(negedge scl) begin
    sda_pull = 1'h0;
    if (n + 1 == clash_bit) sda_pull = 1'h1;
    else if (n == 8 && got[7:1] == my_addr) begin
      sda_pull = 1'h1;
      rd = got[0];
    end else if (rd && n > 8 && n < 17) sda_pull = ~tx_byte[16 - n];
  end
endmodule

// file: tb_top.sv
// bench for the two-wire master: apb tasks, wired-and bus, peer model
// assumes the design files and the peer model are compiled before it
`timescale 1ns/100ps
module tb_top;
  import i2m_pkg::*;
  localparam int TO = 200;
  localparam int BAUD = 2;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, tb_scl, tb_sda, s_pull, er, scl_q;
  logic [7:0] paddr, got;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] clash;
  i2m_line_s line_i, m_oe, m_lvl;
  int error_cnt, check_count, cyc, t_rise, per;

  i2m_master #(.TIMEOUT_CYC(TO)) i_i2m_master (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_i(line_i), .line_o(m_lvl), .line_oe(m_oe));
  i2m_peer_model i_i2m_peer_model (.scl(line_i.scl), .sda(line_i.sda), .my_addr(7'h52), .tx_byte(8'h3c),
    .clash_bit(clash), .sda_pull(s_pull), .got(got));
  // wired-and with pull-ups, every party only pulls low
  assign line_i = {~(m_oe.scl | tb_scl), ~(m_oe.sda | tb_sda | s_pull)};

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  // scl period in clk_sys cycles, rise to rise
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    scl_q <= line_i.scl;
    if (line_i.scl && !scl_q) begin
      per <= cyc - t_rise;
      t_rise <= cyc;
    end
  end

  task conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    q = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  // status polled until the masked bits match, bounded
  task poll(input string nm, input logic [31:0] m, input logic [31:0] e);
    int i;
    i = 0;
    apb(1'h0, ADDR_STAT, 32'h0);
    while ((q & m) !== e && i < 300) begin
      apb(1'h0, ADDR_STAT, 32'h0);
      i++;
    end
    chk(nm, e, q & m);
  endtask
  // bench as a foreign party, half a 48 ns link period per step
  task line(input logic c, input logic d);
    tb_scl <= c;
    tb_sda <= d;
    repeat (6) @(posedge clk_sys);
  endtask
  task fstart;
    line(1'h0, 1'h1);
    line(1'h1, 1'h1);
    line(1'h1, 1'h0);
    line(1'h0, 1'h0);
  endtask
  task fstop;
    line(1'h1, 1'h1);
    line(1'h0, 1'h1);
    line(1'h0, 1'h0);
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end

  initial begin
    rst_b = 1'h0;
    {psel, penable, pwrite, tb_scl, tb_sda} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    clash = 4'h0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    rdc("stat", ADDR_STAT, 32'hff, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'h1, ADDR_CTRL, 32'h1);
    rdc("bus", ADDR_STAT, 32'h3, BS_UNKNOWN);
    fstop;
    rdc("bus", ADDR_STAT, 32'h3, BS_IDLE);
    fstart;
    rdc("bus", ADDR_STAT, 32'h3, BS_BUSY);
    fstop;
    rdc("bus", ADDR_STAT, 32'h3, BS_IDLE);
    apb(1'h1, ADDR_CTRL, 32'h0);
    apb(1'h1, ADDR_CTRL, 32'h1);
    rdc("bus", ADDR_STAT, 32'h3, BS_UNKNOWN);
    apb(1'h1, ADDR_STAT, 32'h1);
    rdc("bus", ADDR_STAT, 32'h3, BS_IDLE);
    apb(1'h1, ADDR_CTRL, 32'h0);
    apb(1'h1, ADDR_CTRL, 32'h3);
    rdc("ctrl", ADDR_CTRL, 32'hff, 32'h3);
    rdc("bus", ADDR_STAT, 32'h3, BS_UNKNOWN);
    repeat (TO + 60) @(posedge clk_sys);
    rdc("bus", ADDR_STAT, 32'h3, BS_IDLE);
    fstart;
    rdc("bus", ADDR_STAT, 32'h3, BS_BUSY);
    repeat (TO + 60) @(posedge clk_sys);
    rdc("bus", ADDR_STAT, 32'h3, BS_IDLE);
    apb(1'h1, ADDR_CTRL, 32'h1);
    apb(1'h1, ADDR_BAUD, BAUD);
    rdc("baud", ADDR_BAUD, 32'hff, BAUD);
    // acked write address, scl held low until the write flag is cleared
    apb(1'h1, ADDR_SLV, 32'ha4);
    rdc("bus", ADDR_STAT, 32'h3, BS_OWNER);
    poll("wif", 32'h40, 32'h40);
    rdc("stat", ADDR_STAT, 32'hdf, 32'h42);
    chk("addr", 32'ha4, {24'h0, got});
    chk("line_o", 32'h0, {30'h0, m_lvl});
    chk("period", 32'h1, {31'h0, per >= 10 + 2 * BAUD && per <= 16 + 2 * BAUD});
    repeat (30) @(posedge clk_sys);
    chk("scl_hold", 32'h0, {31'h0, line_i.scl});
    apb(1'h1, ADDR_STAT, 32'h40);
    repeat (30) @(posedge clk_sys);
    chk("scl_free", 32'h1, {31'h0, line_i.scl});
    // repeated start while owning keeps the owner state
    apb(1'h1, ADDR_SLV, 32'ha4);
    poll("wif", 32'h40, 32'h40);
    rdc("bus", ADDR_STAT, 32'h3, BS_OWNER);
    apb(1'h1, ADDR_CTRL, 32'h5);
    poll("bus", 32'h3, BS_IDLE);
    // acked read address, one byte in
    apb(1'h1, ADDR_SLV, 32'ha5);
    poll("rif", 32'h80, 32'h80);
    rdc("stat", ADDR_STAT, 32'hdc, 32'h80);
    rdc("data", ADDR_DATA, 32'hff, 32'h3c);
    apb(1'h1, ADDR_STAT, 32'h80);
    apb(1'h1, ADDR_CTRL, 32'h5);
    poll("bus", 32'h3, BS_IDLE);
    // start deferred by a busy bus, address then refused
    fstart;
    apb(1'h1, ADDR_SLV, 32'h22);
    repeat (60) @(posedge clk_sys);
    chk("oe_wait", 32'h0, {30'h0, m_oe});
    fstop;
    poll("wif", 32'h40, 32'h40);
    rdc("stat", ADDR_STAT, 32'h5c, 32'h50);
    apb(1'h1, ADDR_STAT, 32'h40);
    apb(1'h1, ADDR_CTRL, 32'h5);
    poll("bus", 32'h3, BS_IDLE);
    // rival wins the first address bit
    clash <= 4'h1;
    apb(1'h1, ADDR_SLV, 32'ha4);
    poll("wif", 32'h40, 32'h40);
    rdc("stat", ADDR_STAT, 32'h4f, 32'h4b);
    chk("oe_lost", 32'h0, {30'h0, m_oe});
    clash <= 4'h0;
    fstop;
    rdc("bus", ADDR_STAT, 32'h3, BS_IDLE);
    // foreign start while scl is high in mid address is a bus error
    apb(1'h1, ADDR_STAT, 32'h48);
    apb(1'h1, ADDR_SLV, 32'ha4);
    @(posedge line_i.scl);
    @(posedge clk_sys);
    tb_sda <= 1'h1;
    repeat (6) @(posedge clk_sys);
    rdc("stat", ADDR_STAT, 32'h4f, 32'h4f);
    chk("oe_berr", 32'h0, {30'h0, m_oe});
    line(1'h0, 1'h0);
    rdc("bus", ADDR_STAT, 32'h3, BS_IDLE);
    conclude();
  end
endmodule
